// File: dv/env_side.sv
// Sensor and fan side: supplies measurements, times fan duty
`timescale 1ns/10ps
module env_side import hwmon_pkg::*; (
    input wire logic pclk,
    input wire logic [2:0] fan_drive_out,
    output sensor_sample_s sample,
    output logic meas_done
);
    initial begin
        sample = '0;
        meas_done = 1'b0;
    end
    // One measurement; voltages alike and tachs alike on all channels
    task automatic measure(input logic [7:0] v, input logic [23:0] t, input logic [7:0] f);
        @(posedge pclk);
        sample.volt <= {3{v}};
        sample.temp <= t;
        sample.tach <= {3{f}};
        meas_done <= 1'b1;
        @(posedge pclk);
        meas_done <= 1'b0;
    endtask
    // Two periods pass first, so a new duty was taken at a wrap
    task automatic duty(output logic [2:0][7:0] d);
        d = '0;
        repeat (256) @(posedge pclk);
        repeat (128) begin
            @(posedge pclk);
            for (int i = 0; i < 3; i++) d[i] = d[i] + 8'(fan_drive_out[i]);
        end
    endtask
endmodule

// File: dv/hw_monitor_bench.sv
// Self-checking bench of the environment monitor
`timescale 1ns/10ps
`include "hwmon_cfg.svh"
module hw_monitor_bench import hwmon_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic meas_done, monitor_run, irq_out, sys_mgmt_irq_n, re;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [2:0] fan_drive_out;
    logic [2:0][7:0] dq;
    sensor_sample_s sample;
    int err_total, tests_run;
    // ----
    // Rows: volt/fan, temperature, fan output
    // ----
    logic [7:0] rv [4] = '{8'h5a, 8'h0a, 8'h50, 8'h14};
    logic [7:0] rt [4] = '{8'h3c, 8'h28, 8'h32, 8'h33};
    logic [5:0] ev [4] = '{6'h15, 6'h2a, 6'h00, 6'h00};
    logic [2:0] ef [4] = '{3'h7, 3'h0, 3'h0, 3'h7};
    logic [23:0] tt [6] = '{24'h1000c9, 24'hf0191e, 24'h100010, 24'hf0191e, 24'h1a18e0, 24'h1000e0};
    logic tr [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [2:0] te [6] = '{3'h0, 3'h0, 3'h7, 3'h6, 3'h5, 3'h0};
    fan_mode_e fm [10] = '{FAN_OFF, FAN_ON, FAN_SW_PWM, FAN_SW_PWM, FAN_AUTO,
                           FAN_AUTO, FAN_AUTO, FAN_AUTO, FAN_AUTO, FAN_AUTO};
    logic [7:0] fd [10] = '{8'h00, 8'h00, 8'h55, 8'hd5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ft [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h23, 8'h19, 8'h0a, 8'h19, 8'h1f, 8'h33};
    logic [7:0] fe [10] = '{8'h00, 8'h80, 8'h55, 8'h55, 8'h34, 8'h20, 8'h00, 8'h00, 8'h24, 8'h80};
    hw_monitor i_hw_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample(sample), .meas_done(meas_done), .monitor_run(monitor_run),
        .irq_out(irq_out), .sys_mgmt_irq_n(sys_mgmt_irq_n), .fan_drive_out(fan_drive_out));
    env_side i_env_side (.pclk(pclk), .fan_drive_out(fan_drive_out), .sample(sample), .meas_done(meas_done));
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        check(32'(n < 16), 32'h1);
        if (n >= 16) report_and_stop();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rq, re);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rq, re);
        check(rq, x);
    endtask
    task automatic tick();
        @(posedge pclk);
        #1;
    endtask
    task automatic lines(input logic on);
        check(32'(irq_out), 32'(on));
        check(32'(sys_mgmt_irq_n), 32'(!on));
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_total = 0;
        tests_run = 0;
        repeat (10) @(posedge pclk);
        #1;
        check(32'({irq_out, sys_mgmt_irq_n, fan_drive_out, monitor_run, pready, pslverr}), 32'h40);
        check(prdata, 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(`A_CFG, 32'(`CFG_RST));
        rdc(`A_SMI_MASK, 32'(`MASK_RST));
        rdc(`A_AUTO, `AUTO_RST);
        rdc(`A_TLIM, 32'(`LIM_RST));
        apb(1'b1, 8'hfc, 32'hffffffff, rq, re);
        check(32'(re), 32'h1);
        rdc(8'hfc, 32'h0);
        check(32'(re), 32'h1);
        wr(`A_CFG, 32'h7);
        tick();
        check(32'(monitor_run), 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(8'(`A_VLIM + 4 * i), 32'h5014);
            wr(8'(`A_FLIM + 4 * i), 32'h32);
            wr(8'(`A_AUTO + 4 * i), 32'h20321e14);
            wr(8'(`A_SLOPE + 4 * i), 32'h3);
        end
        for (int r = 0; r < 4; r++) begin
            i_env_side.measure(rv[r], 24'h0, rt[r]);
            tick();
            lines(ev[r] != 0 || ef[r] != 0);
            rdc(`A_ST_VOLT, 32'(ev[r]));
            rdc(`A_ST_FAN, 32'(ef[r]));
            tick();
            lines(1'b0);
        end
        wr(`A_TLIM, 32'h19e7);
        wr(`A_TLIM + 8'h04, 32'h197f);
        wr(`A_TLIM + 8'h08, 32'h1900);
        wr(`A_ENH, 32'h80);
        for (int r = 0; r < 6; r++) begin
            i_env_side.measure(8'h30, tt[r], 8'h00);
            if (tr[r]) begin
                tick();
                lines(te[r] != 0);
                rdc(`A_ST_TEMP, 32'(te[r]));
            end
        end
        rdc(`A_ST_TEMP, 32'h0);
        // Event lands on the very edge that clears the status
        fork
            apb(1'b0, `A_ST_TEMP, 32'h0, rq, re);
            begin
                repeat (2) @(posedge pclk);
                i_env_side.measure(8'h30, 24'h001900, 8'h00);
            end
        join
        check(rq, 32'h0);
        rdc(`A_ST_TEMP, 32'h2);
        wr(`A_IRQ_MASK, 32'h7073f);
        i_env_side.measure(8'h30, 24'h001900, 8'h00);
        tick();
        check(32'({irq_out, sys_mgmt_irq_n}), 32'h0);
        wr(`A_CFG, 32'h5);
        tick();
        check(32'(sys_mgmt_irq_n), 32'h1);
        rdc(`A_ST_TEMP, 32'h2);
        wr(`A_IRQ_MASK, 32'h0);
        wr(`A_CFG, 32'h7);
        i_env_side.measure(8'h30, 24'h001900, 8'h00);
        tick();
        lines(1'b1);
        wr(`A_CFG, 32'hf);
        tick();
        lines(1'b0);
        check(32'(monitor_run), 32'h0);
        i_env_side.measure(8'h30, 24'hf01900, 8'h00);
        wr(`A_CFG, 32'h7);
        rdc(`A_ST_TEMP, 32'h2);
        i_env_side.measure(8'h30, 24'hf00000, 8'h00);
        rdc(`A_ST_TEMP, 32'h4);
        for (int r = 0; r < 10; r++) begin
            wr(`A_FAN_MODE, 32'({3{fm[r]}}));
            for (int i = 0; i < 3; i++) wr(8'(`A_SW_PWM + 4 * i), 32'(fd[r]));
            i_env_side.measure(8'h30, {3{ft[r]}}, 8'h00);
            i_env_side.duty(dq);
            for (int i = 0; i < 3; i++) check(32'(dq[i]), 32'(fe[r]));
        end
        wr(`A_SLOPE, 32'h7);
        i_env_side.measure(8'h30, 24'h212121, 8'h00);
        i_env_side.duty(dq);
        check(32'(dq[0]), 32'h80);
        check(32'(dq[1]), 32'h2c);
        report_and_stop();
    end
endmodule
bind hw_monitor hw_monitor_chk i_hw_monitor_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample(sample), .meas_done(meas_done),
    .monitor_run(monitor_run), .irq_out(irq_out), .sys_mgmt_irq_n(sys_mgmt_irq_n),
    .fan_drive_out(fan_drive_out));

// File: dv/hw_monitor_chk.sv
// Port-level checker of the environment monitor
`timescale 1ns/10ps
`include "hwmon_cfg.svh"
module hw_monitor_chk import hwmon_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sensor_sample_s sample,
    input wire logic meas_done,
    input wire logic monitor_run,
    input wire logic irq_out,
    input wire logic sys_mgmt_irq_n,
    input wire logic [2:0] fan_drive_out
);
    // ----
    // Shadow of host writes
    // ----
    logic fin;
    logic rd_st;
    logic [31:0] cfg_q;
    logic [31:0] msk_q;
    logic [1:0] mode_q;
    logic [7:0] age_q;
    logic clean_q;
    assign fin = psel && penable && pready && !pslverr;
    assign rd_st = fin && !pwrite && paddr == `A_ST_TEMP;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
            msk_q <= '0;
        end else if (fin && pwrite && paddr == `A_CFG) begin
            cfg_q <= pwdata;
        end else if (fin && pwrite && paddr == `A_IRQ_MASK) begin
            msk_q <= pwdata;
        end
    end
    // Age saturates well past one PWM period, so a new mode has surely landed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= '0;
            age_q <= '0;
        end else if (fin && pwrite && paddr == `A_FAN_MODE) begin
            mode_q <= pwdata[1:0];
            age_q <= '0;
        end else if (age_q != 8'hff) begin
            age_q <= age_q + 8'h01;
        end
    end
    // Any measurement may refill status, so cleanness ends there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clean_q <= 1'b0;
        end else if (meas_done) begin
            clean_q <= 1'b0;
        end else if (rd_st) begin
            clean_q <= 1'b1;
        end
    end
    // ----
    // Assertions
    // ----
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_run_cfg: assert property (monitor_run == (cfg_q[`CFG_START] && !cfg_q[`CFG_HALT]))
        else $error("run flag wrong");
    a_halt_quiet: assert property (cfg_q[`CFG_HALT] |=> !irq_out && sys_mgmt_irq_n)
        else $error("lines active while halted");
    a_irq_gate: assert property (!cfg_q[`CFG_IRQ_EN] |=> !irq_out)
        else $error("irq while disabled");
    a_smi_gate: assert property (!cfg_q[`CFG_SMI_EN] |=> sys_mgmt_irq_n)
        else $error("smi while disabled");
    a_irq_mask: assert property (&msk_q[5:0] && &msk_q[10:8] && &msk_q[18:16] |=> !irq_out)
        else $error("irq while all masked");
    a_fan_off: assert property (age_q == 8'hff && mode_q == FAN_OFF |-> !fan_drive_out[0])
        else $error("fan on in off mode");
    a_fan_on: assert property (age_q == 8'hff && mode_q == FAN_ON |-> fan_drive_out[0])
        else $error("fan off in on mode");
    a_read_clear: assert property (rd_st && clean_q |-> prdata == 32'h0)
        else $error("status not cleared by read");
    a_err_zero: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("error answer malformed");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    c_irq: cover property ($rose(irq_out));
    c_smi: cover property ($fell(sys_mgmt_irq_n));
    c_same: cover property (rd_st && meas_done);
endmodule

// File: logic/fan_channel.sv
// One fan output: on/off level, software PWM or temperature-driven PWM
`timescale 1ns/10ps
`include "hwmon_cfg.svh"
module fan_channel import hwmon_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire fan_mode_e mode,
    input wire logic [6:0] sw_duty,
    input wire fan_auto_s auto_cfg,
    input wire logic [2:0] slope,
    input wire logic [7:0] temp,
    output logic fan_drive_out
);
    logic [6:0] cnt_q;
    logic spin_q;
    logic [7:0] duty_d;
    logic [7:0] duty_q;
    logic signed [8:0] rise;
    logic [15:0] sum;

    // Slope code 0 gives no gain, otherwise a power of two
    function automatic logic [15:0] scale(input logic [8:0] x, input logic [2:0] k);
        logic [15:0] r;
        r = 16'h0000;
        if (k != 3'h0) begin
            r = 16'({7'h00, x} << (k - 3'h1));
        end
        return r;
    endfunction

    // ----------------------------------------
    // Hysteresis between off and start limits
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spin_q <= 1'b0;
        end else if ($signed(temp) > $signed(auto_cfg.start_lim)) begin
            spin_q <= 1'b1;
        end else if ($signed(temp) < $signed(auto_cfg.off_lim)) begin
            spin_q <= 1'b0;
        end
    end

    assign rise = $signed({temp[7], temp}) - $signed({auto_cfg.start_lim[7], auto_cfg.start_lim});

    always_comb begin
        sum = 16'h0000;
        duty_d = 8'h00;
        case (mode)
            FAN_SW_PWM: duty_d = {1'b0, sw_duty};
            FAN_AUTO: begin
                if ($signed(temp) > $signed(auto_cfg.full_lim)) begin
                    duty_d = `PWM_FULL;
                end else if (rise > 9'sh000) begin
                    sum = {9'h000, auto_cfg.start_pwm} + scale(rise, slope);
                    duty_d = (sum > `PWM_SAT) ? `PWM_FULL : sum[7:0];
                end else if (spin_q) begin
                    duty_d = {1'b0, auto_cfg.start_pwm};
                end
            end
            default: duty_d = 8'h00;
        endcase
    end

    // ----------------------------------------
    // PWM generator, 128 steps per period
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 7'h00;
            duty_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 7'h01;
            // Duty only changes at period start to avoid runt pulses
            if (cnt_q == 7'h7f) begin
                duty_q <= duty_d;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_drive_out <= 1'b0;
        end else if (mode == FAN_ON || mode == FAN_OFF) begin
            fan_drive_out <= (mode == FAN_ON);
        end else begin
            fan_drive_out <= ({1'b0, cnt_q} < duty_q);
        end
    end
endmodule

// File: logic/hw_monitor.sv
// Environment monitor: limit checks, status and interrupt lines, fan outputs
//
// What this block does
// - Every limit comparison can raise an interrupt
// - Status registers collect events, cleared on read
// - Clearing status also drops interrupt lines
// - Separate masks and enables for both outputs
// - Halt bit clears lines, stops the loop
// - Voltages high and low, fans low only
// - Interrupt mode: over high sets sticky bit
// - After an over-high event, next event below low limit
// - Enhanced mode: above high or below low
// - Low limit 127 selects comparator mode unless enhanced mode is on
// - Comparator bit re-sets at each measurement while high
// - Fan output on/off or PWM
// - Software PWM uses low seven duty bits
// - Auto: above start limit drives start PWM
// - Auto: PWM grows by rise shifted left by slope minus one
// - Auto: hold start PWM down to off limit
// - Auto: above full limit drives full on
// - Monitoring runs with start set, halt clear
// - Temperatures compared as signed bytes
`timescale 1ns/10ps
`include "hwmon_cfg.svh"
module hw_monitor import hwmon_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sensor_sample_s sample,
    input wire logic meas_done,
    output logic monitor_run,
    output logic irq_out,
    output logic sys_mgmt_irq_n,
    output logic [2:0] fan_drive_out
);
    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    bus_state_e state_q;
    logic [7:0] cfg_q;
    logic [23:0] irq_mask_q;
    logic [23:0] smi_mask_q;
    logic [7:0] enh_q;
    logic [5:0] fan_mode_q;
    logic [6:0] sw_pwm_q [3];
    logic [15:0] vlim_q [3];
    logic [7:0] flim_q [3];
    logic [15:0] tlim_q [3];
    fan_auto_s auto_q [3];
    logic [2:0] slope_q [3];
    logic [5:0] st_volt_q;
    logic [2:0] st_fan_q;
    logic [2:0] st_temp_q;
    logic [2:0] wait_low_q;
    logic [31:0] rd_d;
    logic hit_d;
    logic hit_q;
    logic wr_go;
    logic rd_go;
    logic sample_go;
    logic [5:0] ev_volt;
    logic [2:0] ev_fan;
    logic [2:0] ev_temp;
    logic [2:0] enh;
    logic [23:0] pend;
    logic clr_volt;
    logic clr_fan;
    logic clr_temp;
    logic lines_on;
    logic irq_want;
    logic smi_want;

    // Index of a word inside a three-word bank, 3 when outside it
    function automatic logic [1:0] bank_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off = a - base;
        return (a >= base && off < 8'h0c && off[1:0] == 2'b00) ? off[3:2] : 2'h3;
    endfunction

    // Low limit at its top value turns an input into a comparator unless enhanced mode is on
    function automatic logic cmp_mode(input logic [15:0] lim);
        return lim[7:0] == `TEMP_CMP_MODE;
    endfunction

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // One wait state: decode in WAIT, answer in DONE from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= BUS_IDLE;
        end else begin
            case (state_q)
                BUS_IDLE: state_q <= (psel && !penable) ? BUS_WAIT : BUS_IDLE;
                BUS_WAIT: state_q <= (psel && penable) ? BUS_DONE : BUS_WAIT;
                BUS_DONE: state_q <= BUS_IDLE;
                default: state_q <= BUS_IDLE;
            endcase
        end
    end

    assign pready = (state_q == BUS_DONE);
    assign pslverr = pready && !hit_q;
    assign wr_go = pready && psel && penable && pwrite && hit_q;
    assign rd_go = pready && psel && penable && !pwrite;

    always_comb begin
        rd_d = 32'h00000000;
        hit_d = 1'b1;
        if (paddr == `A_CFG) begin
            rd_d = {24'h000000, cfg_q};
        end else if (paddr == `A_ST_VOLT) begin
            rd_d = {26'h0000000, st_volt_q};
        end else if (paddr == `A_ST_FAN) begin
            rd_d = {29'h00000000, st_fan_q};
        end else if (paddr == `A_ST_TEMP) begin
            rd_d = {29'h00000000, st_temp_q};
        end else if (paddr == `A_IRQ_MASK) begin
            rd_d = {8'h00, irq_mask_q};
        end else if (paddr == `A_SMI_MASK) begin
            rd_d = {8'h00, smi_mask_q};
        end else if (paddr == `A_ENH) begin
            rd_d = {24'h000000, enh_q};
        end else if (paddr == `A_FAN_MODE) begin
            rd_d = {26'h0000000, fan_mode_q};
        end else if (bank_idx(paddr, `A_SW_PWM) != 2'h3) begin
            rd_d = {25'h0000000, sw_pwm_q[bank_idx(paddr, `A_SW_PWM)]};
        end else if (bank_idx(paddr, `A_VLIM) != 2'h3) begin
            rd_d = {16'h0000, vlim_q[bank_idx(paddr, `A_VLIM)]};
        end else if (bank_idx(paddr, `A_FLIM) != 2'h3) begin
            rd_d = {24'h000000, flim_q[bank_idx(paddr, `A_FLIM)]};
        end else if (bank_idx(paddr, `A_TLIM) != 2'h3) begin
            rd_d = {16'h0000, tlim_q[bank_idx(paddr, `A_TLIM)]};
        end else if (bank_idx(paddr, `A_AUTO) != 2'h3) begin
            rd_d = {1'b0, auto_q[bank_idx(paddr, `A_AUTO)]};
        end else if (bank_idx(paddr, `A_SLOPE) != 2'h3) begin
            rd_d = {29'h00000000, slope_q[bank_idx(paddr, `A_SLOPE)]};
        end else begin
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            hit_q <= 1'b0;
        end else if (state_q == BUS_WAIT) begin
            prdata <= pwrite ? 32'h00000000 : rd_d;
            hit_q <= hit_d;
        end
    end

    // ----------------------------------------
    // Software-written control
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `CFG_RST;
            irq_mask_q <= `MASK_RST;
            smi_mask_q <= `MASK_RST;
            enh_q <= 8'h00;
            fan_mode_q <= 6'h00;
        end else if (wr_go) begin
            if (paddr == `A_CFG) begin
                cfg_q <= pwdata[7:0];
            end else if (paddr == `A_IRQ_MASK) begin
                irq_mask_q <= pwdata[23:0];
            end else if (paddr == `A_SMI_MASK) begin
                smi_mask_q <= pwdata[23:0];
            end else if (paddr == `A_ENH) begin
                enh_q <= pwdata[7:0];
            end else if (paddr == `A_FAN_MODE) begin
                fan_mode_q <= pwdata[5:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `NCH; i++) begin
                sw_pwm_q[i] <= 7'h00;
                vlim_q[i] <= `LIM_RST;
                flim_q[i] <= 8'h00;
                tlim_q[i] <= `LIM_RST;
                auto_q[i] <= 31'(`AUTO_RST);
                slope_q[i] <= 3'h0;
            end
        end else if (wr_go) begin
            for (int i = 0; i < `NCH; i++) begin
                if (bank_idx(paddr, `A_SW_PWM) == 2'(i)) sw_pwm_q[i] <= pwdata[6:0];
                if (bank_idx(paddr, `A_VLIM) == 2'(i)) vlim_q[i] <= pwdata[15:0];
                if (bank_idx(paddr, `A_FLIM) == 2'(i)) flim_q[i] <= pwdata[7:0];
                if (bank_idx(paddr, `A_TLIM) == 2'(i)) tlim_q[i] <= pwdata[15:0];
                if (bank_idx(paddr, `A_AUTO) == 2'(i)) auto_q[i] <= pwdata[30:0];
                if (bank_idx(paddr, `A_SLOPE) == 2'(i)) slope_q[i] <= pwdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // Limit comparisons
    // ----------------------------------------
    assign monitor_run = cfg_q[`CFG_START] && !cfg_q[`CFG_HALT];
    assign sample_go = meas_done && monitor_run;
    assign enh = {enh_q[`ENH_B2], enh_q[`ENH_B1], enh_q[`ENH_B0]};

    // Read-clear strobes, one per status word
    assign clr_volt = rd_go && paddr == `A_ST_VOLT;
    assign clr_fan = rd_go && paddr == `A_ST_FAN;
    assign clr_temp = rd_go && paddr == `A_ST_TEMP;

    always_comb begin
        for (int i = 0; i < `NCH; i++) begin
            ev_volt[2 * i] = sample.volt[i] > vlim_q[i][15:8];
            ev_volt[2 * i + 1] = sample.volt[i] < vlim_q[i][7:0];
            // Count is a period, so a slow fan shows as a large count
            ev_fan[i] = sample.tach[i] > flim_q[i];
            if (enh[i]) begin
                ev_temp[i] = ($signed(sample.temp[i]) > $signed(tlim_q[i][15:8])) ||
                    ($signed(sample.temp[i]) < $signed(tlim_q[i][7:0]));
            end else if (cmp_mode(tlim_q[i])) begin
                ev_temp[i] = $signed(sample.temp[i]) >= $signed(tlim_q[i][15:8]);
            end else if (wait_low_q[i]) begin
                ev_temp[i] = $signed(sample.temp[i]) < $signed(tlim_q[i][7:0]);
            end else begin
                ev_temp[i] = $signed(sample.temp[i]) > $signed(tlim_q[i][15:8]);
            end
        end
    end

    // Interrupt-mode arming flips on each accepted crossing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_low_q <= 3'h0;
        end else if (sample_go) begin
            for (int i = 0; i < `NCH; i++) begin
                if (!enh[i] && !cmp_mode(tlim_q[i]) && ev_temp[i]) begin
                    wait_low_q[i] <= !wait_low_q[i];
                end
            end
        end
    end

    // ----------------------------------------
    // Sticky status, cleared by reading
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_volt_q <= 6'h00;
            st_fan_q <= 3'h0;
            st_temp_q <= 3'h0;
        end else begin
            // Set beats clear so a coincident event survives the read
            st_volt_q <= (st_volt_q & ~{6{clr_volt}}) |
                (ev_volt & {6{sample_go}});
            st_fan_q <= (st_fan_q & ~{3{clr_fan}}) |
                (ev_fan & {3{sample_go}});
            st_temp_q <= (st_temp_q & ~{3{clr_temp}}) |
                (ev_temp & {3{sample_go}});
        end
    end

    // ----------------------------------------
    // Interrupt lines
    // ----------------------------------------
    assign pend = {5'h00, st_temp_q, 5'h00, st_fan_q, 2'h0, st_volt_q};

    // Halt overrides both enables so a stopped loop leaves the lines quiet
    assign lines_on = !cfg_q[`CFG_HALT];
    assign irq_want = cfg_q[`CFG_IRQ_EN] && lines_on && |(pend & ~irq_mask_q);
    assign smi_want = cfg_q[`CFG_SMI_EN] && lines_on && |(pend & ~smi_mask_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out <= 1'b0;
            sys_mgmt_irq_n <= 1'b1;
        end else begin
            irq_out <= irq_want;
            sys_mgmt_irq_n <= !smi_want;
        end
    end

    // ----------------------------------------
    // Fan outputs
    // ----------------------------------------
    for (genvar g = 0; g < `NCH; g++) begin : g_fan
        fan_channel i_fan_channel (
            .pclk(pclk),
            .presetn(presetn),
            .mode(fan_mode_e'(fan_mode_q[2 * g +: 2])),
            .sw_duty(sw_pwm_q[g]),
            .auto_cfg(auto_q[g]),
            .slope(slope_q[g]),
            .temp(sample.temp[g]),
            .fan_drive_out(fan_drive_out[g])
        );
    end
endmodule

// File: logic/hwmon_cfg.svh
// Register offsets, field positions, reset values and fixed figures of the monitor
`ifndef HWMON_CFG_SVH
`define HWMON_CFG_SVH

`define NCH 3
`define A_CFG 8'h00
`define A_ST_VOLT 8'h04
`define A_ST_FAN 8'h08
`define A_ST_TEMP 8'h0c
`define A_IRQ_MASK 8'h10
`define A_SMI_MASK 8'h14
`define A_ENH 8'h18
`define A_FAN_MODE 8'h1c
`define A_SW_PWM 8'h20
`define A_VLIM 8'h30
`define A_FLIM 8'h40
`define A_TLIM 8'h50
`define A_AUTO 8'h60
`define A_SLOPE 8'h70

`define CFG_START 0
`define CFG_SMI_EN 1
`define CFG_IRQ_EN 2
`define CFG_HALT 3
`define ENH_B0 3
`define ENH_B1 6
`define ENH_B2 7

`define MASK_VOLT_LSB 0
`define MASK_FAN_LSB 8
`define MASK_TEMP_LSB 16

`define CFG_RST 8'h00
`define MASK_RST 24'h000000
`define LIM_RST 16'h0000
`define AUTO_RST 32'h007f0000
`define TEMP_CMP_MODE 8'h7f
`define PWM_FULL 8'h80
`define PWM_SAT 16'h0080

`endif

// File: logic/hwmon_pkg.sv
// Types shared by the monitor and its fan channels
package hwmon_pkg;
    typedef enum logic [1:0] {
        FAN_OFF = 2'b00,
        FAN_ON = 2'b01,
        FAN_SW_PWM = 2'b10,
        FAN_AUTO = 2'b11
    } fan_mode_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b11
    } bus_state_e;

    typedef struct packed {
        logic [6:0] start_pwm;
        logic [7:0] full_lim;
        logic [7:0] start_lim;
        logic [7:0] off_lim;
    } fan_auto_s;

    typedef struct packed {
        logic [2:0][7:0] volt;
        logic [2:0][7:0] temp;
        logic [2:0][7:0] tach;
    } sensor_sample_s;
endpackage
